// >>> rtl/cpu_core.sv
// cpu_core: two-phase 8-bit risc sequencer, alu, stack and data planes
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cpu_core
  import cpu_core_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // program rom
  output logic [PC_W-1:0] rom_addr,
  input wire logic [IR_W-1:0] rom_data,
  // write-only data plane
  output wplane_wr_t wplane,
  // interrupt request, level
  input wire logic irq_req
);

  core_state_t s_q;
  core_state_t s_d;

  logic commit;
  logic exec;
  logic branch;
  logic skip;
  logic pop;
  logic do_call;
  logic is_interrupt_exit;
  logic is_wplane;
  logic irq_take;
  logic wr_w;
  logic wr_f;
  logic aff_c;
  logic aff_dc;
  logic aff_z;
  logic nc;
  logic ndc;
  logic [DW-1:0] res;
  logic [DW-1:0] fv;
  logic [DW-1:0] st;
  logic [DW+1:0] sum;
  logic [FA_W-1:0] fa;
  logic [FA_W-1:0] ea;
  logic [PC_W-1:0] target;
  logic [SP_W-1:0] sp_dec;
  logic [SP_W-1:0] sp_inc;
  logic [2:0] bsel;

  function automatic logic [DW+1:0] alu_add(logic [DW-1:0] a, logic [DW-1:0] b, logic cin);
    logic [DW:0] full;
    logic [4:0] half;
    full = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
    half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {full[DW], half[4], full[DW-1:0]};
  endfunction : alu_add

  // circular stack: a seventh push silently lands on the oldest entry
  function automatic core_state_t stack_push(core_state_t s, logic [PC_W-1:0] v);
    core_state_t r;
    r = s;
    r.stk[s.sp] = v;
    r.sp = (s.sp == SP_W'(STACK_DEPTH - 1)) ? '0 : s.sp + 1'b1;
    return r;
  endfunction : stack_push

  function automatic logic [FA_W-1:0] eff_addr(logic [FA_W-1:0] a, logic [DW-1:0] ptr);
    return (a == FA_INDIRECT) ? ptr[FA_W-1:0] : a;
  endfunction : eff_addr

  assign sp_dec = (s_q.sp == '0) ? SP_W'(STACK_DEPTH - 1) : s_q.sp - 1'b1;
  assign sp_inc = (s_q.sp == SP_W'(STACK_DEPTH - 1)) ? '0 : s_q.sp + 1'b1;

  always_comb begin
    s_d = s_q;
    commit = 1'b0;
    branch = 1'b0;
    skip = 1'b0;
    pop = 1'b0;
    do_call = 1'b0;
    is_interrupt_exit = 1'b0;
    is_wplane = 1'b0;
    irq_take = 1'b0;
    wr_w = 1'b0;
    wr_f = 1'b0;
    aff_c = 1'b0;
    aff_dc = 1'b0;
    aff_z = 1'b0;
    nc = s_q.status[ST_C];
    ndc = s_q.status[ST_DC];
    res = '0;
    sum = '0;
    target = s_q.pc;
    bsel = s_q.ir[8:6];
    s_d.wpl.we = 1'b0;
    // bit forms carry only six address bits: lower half of the plane
    fa = (s_q.ir[13:12] == GRP_BITLIT && !s_q.ir[11]) ? {1'b0, s_q.ir[5:0]} : s_q.ir[6:0];
    ea = eff_addr(fa, s_q.pointer);
    case (ea)
      FA_PC_LOW: fv = s_q.pc[7:0];
      FA_STATUS: fv = s_q.status;
      FA_POINTER: fv = s_q.pointer;
      default: fv = s_q.file[ea];
    endcase

    // bus: write lands in data phase, read snapshot taken in address phase
    s_d.bus_wr = 1'b0;
    if (s_q.bus_wr && s_q.bus_addr == REG_CTRL) begin
      s_d.halt = hwdata[CTRL_HALT];
    end
    if (hsel && hready && htrans[1]) begin
      s_d.bus_wr = hwrite;
      s_d.bus_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          REG_CTRL: s_d.hrdata = {31'h0, s_d.halt};
          REG_CORE: s_d.hrdata = {8'h00, s_q.w, 1'b0, s_q.interrupt_exit_pend, s_q.iflag, s_q.pc};
          REG_FLAGS: s_d.hrdata = {13'h0, s_q.sp, s_q.pointer, s_q.status};
          default: s_d.hrdata = 32'h0000_0000;
        endcase
      end
    end

    if (!s_q.halt) begin
      unique case (s_q.phase)
        PH_FIRST: begin
          s_d.pc = s_q.npc;
          s_d.phase = PH_SECOND;
        end
        PH_SECOND: begin
          commit = 1'b1;
          s_d.ir = rom_data;
          s_d.phase = PH_FIRST;
        end
      endcase
    end
    exec = commit && !s_q.flush;

    // the ir captured at the previous commit, two clocks back, executes now, while the next word is fetched
    if (exec) begin
      unique case (s_q.ir[13:12])
        GRP_BYTE: begin
          wr_f = s_q.ir[7];
          wr_w = !s_q.ir[7];
          case (s_q.ir[11:8])
            OP_MISC: begin
              wr_w = 1'b0;
              if (s_q.ir[7]) begin
                res = s_q.w;
              end else if (s_q.ir[6:0] == MISC_SUB_EXIT) begin
                pop = 1'b1;
              end else if (s_q.ir[6:0] == MISC_IRQ_EXIT) begin
                pop = 1'b1;
                is_interrupt_exit = 1'b1;
              end else if (!s_q.ir[6] && s_q.ir[6:0] != MISC_NOP &&
                           s_q.ir[6:0] != MISC_SLEEP && s_q.ir[6:0] != MISC_CLRWDT) begin
                is_wplane = 1'b1;
              end
            end
            OP_CLR: begin
              res = '0;
              aff_z = 1'b1;
            end
            OP_SUB: begin
              sum = alu_add(fv, ~s_q.w, 1'b1);
              {nc, ndc, res} = sum;
              {aff_c, aff_dc, aff_z} = 3'h7;
            end
            OP_ADD: begin
              sum = alu_add(fv, s_q.w, 1'b0);
              {nc, ndc, res} = sum;
              {aff_c, aff_dc, aff_z} = 3'h7;
            end
            OP_DEC: {aff_z, res} = {1'b1, fv - 8'h01};
            OP_IOR: {aff_z, res} = {1'b1, fv | s_q.w};
            OP_AND: {aff_z, res} = {1'b1, fv & s_q.w};
            OP_XOR: {aff_z, res} = {1'b1, fv ^ s_q.w};
            OP_MOVF: begin
              res = fv;
              aff_z = s_q.ir[7];
              wr_f = 1'b0;
            end
            OP_COM: {aff_z, res} = {1'b1, ~fv};
            OP_INC: {aff_z, res} = {1'b1, fv + 8'h01};
            OP_DECSZ: begin
              res = fv - 8'h01;
              skip = (res == 8'h00);
            end
            OP_INCSZ: begin
              res = fv + 8'h01;
              skip = (res == 8'h00);
            end
            OP_RR: {aff_c, nc, res} = {1'b1, fv[0], s_q.status[ST_C], fv[7:1]};
            OP_RL: {aff_c, nc, res} = {1'b1, fv[7], fv[6:0], s_q.status[ST_C]};
            OP_SWAP: res = {fv[3:0], fv[7:4]};
          endcase
        end
        GRP_BITLIT: begin
          if (!s_q.ir[11]) begin
            res = fv;
            unique case (s_q.ir[10:9])
              2'h0: {wr_f, res[bsel]} = 2'b10;
              2'h1: {wr_f, res[bsel]} = 2'b11;
              2'h2: skip = !fv[bsel];
              2'h3: skip = fv[bsel];
            endcase
          end else begin
            wr_w = 1'b1;
            case (s_q.ir[10:8])
              LIT_EXIT: begin
                res = s_q.ir[7:0];
                pop = 1'b1;
              end
              LIT_MOV: res = s_q.ir[7:0];
              LIT_IOR: {aff_z, res} = {1'b1, s_q.w | s_q.ir[7:0]};
              LIT_AND: {aff_z, res} = {1'b1, s_q.w & s_q.ir[7:0]};
              LIT_XOR: {aff_z, res} = {1'b1, s_q.w ^ s_q.ir[7:0]};
              LIT_ADD: begin
                sum = alu_add(s_q.w, s_q.ir[7:0], 1'b0);
                {nc, ndc, res} = sum;
                {aff_c, aff_dc, aff_z} = 3'h7;
              end
              default: wr_w = 1'b0;
            endcase
          end
        end
        GRP_CALL, GRP_JUMP: begin
          do_call = (s_q.ir[13:12] == GRP_CALL);
          branch = 1'b1;
          target = {s_q.status[ST_ROM_PAGE], s_q.ir[11:0]};
        end
      endcase
    end

    // write-back
    st = s_q.status;
    if (wr_w) begin
      s_d.w = res;
    end
    if (is_wplane) begin
      s_d.wpl = '{we: 1'b1, addr: s_q.ir[WPLANE_AW-1:0], data: s_q.w};
    end
    if (wr_f) begin
      case (ea)
        FA_PC_LOW: begin
          branch = 1'b1;
          target = {s_q.pc[PC_W-1:8], res};
        end
        // result cannot overwrite flags that the same op computes
        FA_STATUS: st = (aff_c | aff_dc | aff_z) ? {res[7:3], s_q.status[2:0]} : res;
        FA_POINTER: s_d.pointer = res;
        default: s_d.file[ea] = res;
      endcase
    end
    if (aff_c) st[ST_C] = nc;
    if (aff_dc) st[ST_DC] = ndc;
    if (aff_z) st[ST_Z] = (res == 8'h00);
    s_d.status = st;

    if (pop) begin
      branch = 1'b1;
      target = s_q.stk[sp_dec];
      s_d.sp = sp_dec;
    end
    if (do_call) begin
      s_d = stack_push(s_d, s_q.pc);
    end
    if (is_interrupt_exit) begin
      s_d.interrupt_exit_pend = 1'b1;
    end else if (exec && s_q.interrupt_exit_pend) begin
      s_d.interrupt_exit_pend = 1'b0;
      s_d.iflag = 1'b0;
    end

    if (commit) begin
      s_d.npc = branch ? target : s_q.pc + 13'h0001;
      s_d.flush = branch | skip;
      // taken only at a plain instruction boundary; iflag blocks nesting
      if (irq_req && !s_q.iflag && !branch && !skip) begin
        irq_take = 1'b1;
        s_d = stack_push(s_d, s_q.pc);
        s_d.npc = IRQ_VECTOR;
        s_d.flush = 1'b1;
        s_d.iflag = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign rom_addr = s_q.pc;
  assign wplane = s_q.wpl;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_exec_call;
    exec && s_q.ir[13:12] == GRP_CALL;
  endsequence
  sequence s_flow;
    commit && (branch || skip || irq_take);
  endsequence

  property p_phase_alt;
    !s_q.halt |=> s_q.phase != $past(s_q.phase);
  endproperty
  a_phase_alt: assert property (p_phase_alt) else $error("phase did not alternate");

  property p_pc_load;
    (s_q.phase == PH_FIRST && !s_q.halt) |=> s_q.pc == $past(s_q.npc);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc not loaded in first phase");

  property p_pc_stable;
    s_q.phase == PH_SECOND |=> $stable(s_q.pc);
  endproperty
  a_pc_stable: assert property (p_pc_stable) else $error("pc moved in second phase");

  property p_ir_fetch;
    commit |=> s_q.ir == $past(rom_data);
  endproperty
  a_ir_fetch: assert property (p_ir_fetch) else $error("ir not captured from rom");

  property p_seq_pc;
    (commit && !branch && !skip && !irq_req) |=> s_q.npc == $past(s_q.pc) + 13'h0001;
  endproperty
  a_seq_pc: assert property (p_seq_pc) else $error("pc did not advance by one");

  property p_irq_entry;
    irq_take |=> (s_q.npc == IRQ_VECTOR && s_q.iflag && s_q.flush && s_q.sp == $past(sp_inc));
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");

  property p_call;
    s_exec_call |=> (s_q.npc[11:0] == $past(s_q.ir[11:0]) &&
                     s_q.npc[12] == $past(s_q.status[ST_ROM_PAGE]) &&
                     s_q.sp == $past(sp_inc));
  endproperty
  a_call: assert property (p_call) else $error("call target or push wrong");

  property p_return;
    (exec && pop) |=> (s_q.npc == $past(s_q.stk[sp_dec]) && s_q.sp == $past(sp_dec));
  endproperty
  a_return: assert property (p_return) else $error("return did not pop stack");

  property p_flow_slot;
    s_flow |=> s_q.flush ##1 (s_q.flush && (s_q.phase == PH_SECOND || s_q.halt));
  endproperty
  a_flow_slot: assert property (p_flow_slot) else $error("flow change kept next word");

  property p_iflag_hold;
    (s_q.iflag && !s_q.interrupt_exit_pend) |=> s_q.iflag;
  endproperty
  a_iflag_hold: assert property (p_iflag_hold) else $error("iflag dropped early");

  property p_zero_flag;
    (exec && aff_z && res == 8'h00) |=> s_q.status[ST_Z];
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set");

  property p_wplane;
    (exec && is_wplane) |=> (s_q.wpl.we && s_q.wpl.data == $past(s_q.w)) ##1 !s_q.wpl.we;
  endproperty
  a_wplane: assert property (p_wplane) else $error("write-only plane copy wrong");

endmodule : cpu_core

// >>> rtl/cpu_core_pkg.sv
// package: constants and carrier types of the 8-bit cpu core
package cpu_core_pkg;
  localparam int PC_W = 13;
  localparam int IR_W = 14;
  localparam int DW = 8;
  localparam int STACK_DEPTH = 6;
  localparam int SP_W = 3;
  localparam int FILE_SIZE = 128;
  localparam int FA_W = 7;
  localparam int WPLANE_AW = 6;
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0001;
  // file-plane special locations
  localparam logic [FA_W-1:0] FA_INDIRECT = 7'h00;
  localparam logic [FA_W-1:0] FA_PC_LOW = 7'h02;
  localparam logic [FA_W-1:0] FA_STATUS = 7'h03;
  localparam logic [FA_W-1:0] FA_POINTER = 7'h04;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_RAM_PAGE = 5;
  localparam int ST_ROM_PAGE = 6;
  // bus register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CORE = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam int CTRL_HALT = 0;
  // instruction groups and codes
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BITLIT = 2'h1;
  localparam logic [1:0] GRP_CALL = 2'h2;
  localparam logic [1:0] GRP_JUMP = 2'h3;
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RR = 4'hC;
  localparam logic [3:0] OP_RL = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  localparam logic [6:0] MISC_NOP = 7'h00;
  localparam logic [6:0] MISC_SLEEP = 7'h03;
  localparam logic [6:0] MISC_CLRWDT = 7'h04;
  localparam logic [6:0] MISC_SUB_EXIT = 7'h40;
  localparam logic [6:0] MISC_IRQ_EXIT = 7'h60;
  localparam logic [2:0] LIT_EXIT = 3'h0;
  localparam logic [2:0] LIT_MOV = 3'h1;
  localparam logic [2:0] LIT_IOR = 3'h2;
  localparam logic [2:0] LIT_AND = 3'h3;
  localparam logic [2:0] LIT_ADD = 3'h4;
  localparam logic [2:0] LIT_XOR = 3'h7;

  typedef enum logic {PH_FIRST, PH_SECOND} phase_t;

  typedef struct packed {
    logic we;
    logic [WPLANE_AW-1:0] addr;
    logic [DW-1:0] data;
  } wplane_wr_t;

  typedef struct packed {
    phase_t phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] npc;
    logic [IR_W-1:0] ir;
    logic flush;
    logic [DW-1:0] w;
    logic [DW-1:0] status;
    logic [DW-1:0] pointer;
    logic [FILE_SIZE-1:0][DW-1:0] file;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0] sp;
    logic iflag;
    logic interrupt_exit_pend;
    logic halt;
    logic bus_wr;
    logic [7:0] bus_addr;
    logic [31:0] hrdata;
    wplane_wr_t wpl;
  } core_state_t;

  // all-zero: pc at reset vector, first phase, nop in ir, running
  localparam core_state_t CORE_RESET = '0;
endpackage : cpu_core_pkg

// >>> test/prog_rom.sv
// program rom and write-only data plane model facing the core
`timescale 1ns/1ps
module prog_rom
  import cpu_core_pkg::*;
(
  // clock
  input wire logic hclk,
  // rom port
  input wire logic [PC_W-1:0] rom_addr,
  output logic [IR_W-1:0] rom_data,
  // write-only plane
  input wire wplane_wr_t wplane
);
  logic [IR_W-1:0] mem [0:8191];
  logic [DW-1:0] wreg [0:63];

  // read without a clock: the core samples at the end of its second phase
  assign rom_data = mem[rom_addr];

  // plane is write-only, so the bench reads the copy kept here
  always @(posedge hclk) begin
    if (wplane.we === 1'b1) begin
      wreg[wplane.addr] <= wplane.data;
    end
  end
endmodule : prog_rom

// >>> test/tb_top.sv
// self-checking bench for the cpu core: programs in rom, state read over ahb
`timescale 1ns/1ps
module tb_top
  import cpu_core_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, irq_req, hreadyout, hresp, hit;
  logic [31:0] haddr, hwdata, hrdata, rd, core_v, flg_v, r;
  logic [1:0] htrans;
  logic [PC_W-1:0] rom_addr, prv;
  logic [IR_W-1:0] rom_data;
  logic [7:0] a, b, v;
  logic [5:0] r1;
  logic [10:0] e;
  wplane_wr_t wplane;
  int n_errors, checks, seed;
  int cyc = 0;
  logic [PC_W-1:0] aq[$];
  int cq[$];

  cpu_core i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rom_addr(rom_addr),
    .rom_data(rom_data), .wplane(wplane), .irq_req(irq_req)
  );

  prog_rom i_rom (.hclk(hclk), .rom_addr(rom_addr), .rom_data(rom_data), .wplane(wplane));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // fetch address trace and hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    prv <= rom_addr;
    if (hresetn === 1'b1 && rom_addr !== prv) begin
      aq.push_back(rom_addr);
      cq.push_back(cyc);
    end
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // entered just after a rising edge; answer taken at the data phase edge
  task bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // freeze for consistent reads; stays frozen so rom reloads cannot race a fetch
  task snap;
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CORE, 32'h0);
    core_v = rd;
    bus(1'b0, REG_FLAGS, 32'h0);
    flg_v = rd;
  endtask : snap

  task start(input int n);
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    aq.delete();
    cq.delete();
    hresetn <= 1'b1;
    repeat (n) @(posedge hclk);
    snap();
  endtask : start

  task put(input int ad, input logic [13:0] w);
    i_rom.mem[ad] = w;
  endtask : put

  task clr;
    for (int i = 0; i < 8192; i++) begin
      i_rom.mem[i] = 14'h0000;
    end
  endtask : clr

  function automatic logic [13:0] lit(input logic [2:0] c, input logic [7:0] k);
    return {GRP_BITLIT, 1'b1, c, k};
  endfunction : lit

  function automatic logic [13:0] bop(input logic [3:0] o, input logic d, input logic [6:0] f);
    return {GRP_BYTE, o, d, f};
  endfunction : bop

  // expected {w, z, dc, c}; subtraction carries are inverted borrows
  function automatic logic [10:0] alu_exp(input logic sub, input logic [7:0] f, w);
    logic [8:0] s;
    logic [4:0] h;
    s = sub ? {1'b0, f} + {1'b0, ~w} + 9'h001 : {1'b0, f} + {1'b0, w};
    h = sub ? {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01 : {1'b0, f[3:0]} + {1'b0, w[3:0]};
    return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
  endfunction : alu_exp

  initial begin
    seed = 32'hd8f0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    irq_req = 1'b0;
    n_errors = 0;
    checks = 0;
    clr();
    @(posedge hclk);
    start(40);
    chk("first fetch", aq[0], 32'h1);
    for (int k = 1; k < 10; k++) begin
      chk("fetch addr", aq[k], k + 1);
      chk("fetch gap", cq[k] - cq[k - 1], 32'h2);
    end
    $display("test sequence done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      a = r[7:0];
      b = r[15:8];
      if (i[0]) begin
        put(0, lit(LIT_MOV, b));
        put(1, bop(OP_MISC, 1'b1, 7'h10));
        put(2, lit(LIT_MOV, a));
        put(3, bop(OP_SUB, 1'b0, 7'h10));
      end else begin
        put(0, lit(LIT_MOV, a));
        put(1, lit(LIT_ADD, b));
        put(2, 14'h0000);
        put(3, 14'h0000);
      end
      put(4, {GRP_JUMP, 12'h004});
      e = alu_exp(i[0], b, a);
      start(40);
      chk("alu w", core_v[23:16], e[10:3]);
      chk("alu flags", flg_v[2:0], e[2:0]);
    end
    $display("test alu done");
    clr();
    put(0, lit(LIT_MOV, 8'hFF));
    put(1, bop(OP_MISC, 1'b1, FA_STATUS));
    put(2, bop(OP_CLR, 1'b1, FA_STATUS));
    put(3, {GRP_BITLIT, 3'b001, 3'h6, 6'h03});
    put(4, lit(LIT_MOV, 8'h30));
    put(5, bop(OP_MISC, 1'b1, FA_PC_LOW));
    put(13'h0030, {GRP_JUMP, 12'h008});
    put(13'h1008, {GRP_JUMP, 12'h008});
    start(60);
    chk("status", flg_v[7:0], 32'h47);
    chk("page jump", core_v[12:1], 32'h804);
    hit = 1'b0;
    foreach (aq[i]) begin
      if (aq[i] === 13'h0030) begin
        hit = 1'b1;
      end
    end
    chk("pc low write", hit, 32'h1);
    $display("test status done");
    clr();
    put(0, {GRP_CALL, 12'h010});
    for (int i = 1; i < 6; i++) begin
      put(16 * i, {GRP_CALL, 12'(16 * i + 16)});
      put(16 * i + 1, {7'h00, MISC_SUB_EXIT});
    end
    put(13'h0060, lit(LIT_EXIT, 8'h5A));
    put(1, {GRP_JUMP, 12'h001});
    start(120);
    chk("nest fetch", aq[3], 32'h20);
    chk("exit w", core_v[23:16], 32'h5A);
    chk("stack empty", flg_v[18:16], 32'h0);
    chk("return pc", core_v[12:1], 32'h0);
    clr();
    for (int i = 0; i < 7; i++) begin
      put(16 * i, {GRP_CALL, 12'(16 * i + 16)});
    end
    put(13'h0070, {GRP_JUMP, 12'h070});
    start(80);
    chk("stack wrap", flg_v[18:16], 32'h1);
    $display("test stack done");
    clr();
    put(0, {GRP_JUMP, 12'h010});
    put(13'h0011, {GRP_JUMP, 12'h010});
    put(4, {7'h00, MISC_IRQ_EXIT});
    start(30);
    bus(1'b1, REG_CTRL, 32'h0);
    irq_req <= 1'b1;
    for (int i = 0; i < 60 && rom_addr !== 13'h0001; i++) @(posedge hclk);
    chk("vector", rom_addr, 32'h1);
    irq_req <= 1'b0;
    snap();
    chk("iflag set", core_v[13], 32'h1);
    chk("irq push", flg_v[18:16], 32'h1);
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (40) @(posedge hclk);
    snap();
    chk("iflag clear", core_v[13], 32'h0);
    chk("irq pop", flg_v[18:16], 32'h0);
    $display("test interrupt done");
    r = $random(seed);
    v = r[7:0];
    b = {5'h00, r[10:8]};
    r1 = 6'h05 + {2'h0, r[15:12]};
    clr();
    put(0, lit(LIT_MOV, 8'h20));
    put(1, bop(OP_MISC, 1'b1, FA_POINTER));
    put(2, lit(LIT_MOV, v));
    put(3, bop(OP_MISC, 1'b1, FA_INDIRECT));
    put(4, {GRP_BITLIT, 3'b001, b[2:0], 6'h10});
    put(5, bop(OP_MOVF, 1'b0, 7'h20));
    put(6, {8'h00, r1});
    put(7, bop(OP_MOVF, 1'b0, 7'h10));
    put(8, {8'h00, r1 + 6'h20});
    put(9, {GRP_JUMP, 12'h009});
    start(50);
    chk("indirect", i_rom.wreg[r1], v);
    chk("bit set", i_rom.wreg[r1 + 6'h20], 8'h01 << b[2:0]);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd[0], 32'h1);
    bus(1'b1, REG_CTRL, 32'h0);
    chk("resp", hresp, 32'h0);
    chk("ready", hreadyout, 32'h1);
    $display("test planes and bus done");
    end_of_test();
  end
endmodule : tb_top
